// ### tb/gs_monitor_model.sv
module gs_monitor_model #(
    parameter int BLANK_CYC = 4,
    parameter int DISC_CYC  = 8
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic chA,
    input  wire logic chB,
    output logic      monEnable,
    output logic      monDiscrep
);
    timeunit 1ns;
    timeprecision 1ns;
    int lowCnt;
    int discCnt;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= BLANK_CYC;
            discCnt <= 0;
            monEnable <= 1'b0;
            monDiscrep <= 1'b0;
        end else begin
            lowCnt <= (chA && chB) ? 0 : lowCnt + 1;
            monEnable <= (lowCnt < BLANK_CYC);
            discCnt <= (chA != chB) ? discCnt + 1 : 0;
            if (discCnt >= DISC_CYC) begin
                monDiscrep <= 1'b1;
            end
        end
    end
endmodule // gs_monitor_model

// ### tb/gs_supervisor_asserts.sv
module gs_supervisor_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic doorClosedPin,
    input wire logic codeMatchPin,
    input wire logic actBadPin,
    input wire logic comboBadPin,
    input wire logic intFaultPin,
    input wire logic supplyFaultPin,
    input wire logic outAFaultPin,
    input wire logic outBFaultPin,
    input wire logic overTempPin,
    input wire logic safetyOutputA,
    input wire logic safetyOutputB,
    input wire logic diagOut,
    input wire logic ledGreen,
    input wire logic ledRed,
    input wire logic ledYellow,
    input wire logic inhibitNvOut,
    input wire logic codeCapture
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ****************
    // Sequences
    // ****************
    sequence s_doorOpen; !doorClosedPin [*8]; endsequence
    sequence s_bothFault; (outAFaultPin && outBFaultPin) [*8]; endsequence
    sequence s_warnStart;
        $rose(overTempPin) && safetyOutputA && doorClosedPin && codeMatchPin && !outAFaultPin
            && !outBFaultPin && !intFaultPin && !actBadPin;
    endsequence
    // ****************
    // Properties
    // ****************
    property p_doorOff; $fell(doorClosedPin) |-> ##[1:7] (!safetyOutputA && !safetyOutputB);
    endproperty
    a_doorOff: assert property (p_doorOff) else $error("outputs on after door opened");
    property p_intOff; $rose(intFaultPin) |-> ##[1:7] !safetyOutputA; endproperty
    a_intOff: assert property (p_intOff) else $error("outputs on after internal fault");
    property p_immOff;
        $rose(actBadPin || comboBadPin || supplyFaultPin) |-> ##[1:7] !safetyOutputB;
    endproperty
    a_immOff: assert property (p_immOff) else $error("outputs on after fatal fault");
    property p_warnHold; s_warnStart |-> safetyOutputA [*8]; endproperty
    a_warnHold: assert property (p_warnHold) else $error("warning dropped outputs");
    property p_warnDiag; overTempPin [*8] |-> !diagOut; endproperty
    a_warnDiag: assert property (p_warnDiag) else $error("diag high during warning");
    property p_closedLeds; diagOut |-> (ledGreen && ledYellow && !ledRed); endproperty
    a_closedLeds: assert property (p_closedLeds) else $error("wrong leds while closed");
    property p_openLeds; s_doorOpen |-> (!ledYellow && !diagOut); endproperty
    a_openLeds: assert property (p_openLeds) else $error("yellow or diag on while open");
    property p_teachLeds; $rose(codeCapture) |-> ##[0:3] (ledRed && !ledGreen); endproperty
    a_teachLeds: assert property (p_teachLeds) else $error("teach leds wrong");
    property p_lock; s_bothFault |=> (!safetyOutputA && !safetyOutputB); endproperty
    a_lock: assert property (p_lock) else $error("outputs on with both outputs faulty");
    property p_inhibit; $rose(inhibitNvOut) |-> (!safetyOutputA && !safetyOutputB) [*8];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("outputs on during inhibit");
endmodule // gs_supervisor_asserts

// ### tb/gs_supervisor_test.sv
module gs_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 2;
    logic        clk_sys = 0, rst_n = 0, avsRead = 0, avsWrite = 0;
    logic [3:0]  avsAddress = 0, imm = 0, wrn = 0;
    logic [31:0] avsWritedata = 0, q;
    logic        doorClosedPin = 0, actPresentPin = 0, codeMatchPin = 0, codeStoredPin = 0;
    logic        safetyInputA = 1, safetyInputB = 1, teachNvPin = 0, inhibitNvPin = 0;
    wire  [31:0] avsReaddata;
    wire         avsWaitrequest, safetyOutputA, safetyOutputB, diagOut, ledGreen, ledRed;
    wire         ledYellow, teachNvOut, inhibitNvOut, codeCapture, codeCommit;
    wire         monEnable, monDiscrep;
    int          error_cnt = 0, total_checks = 0, n, i;
    logic        y0;
    gs_supervisor #(.TICK_CYC(TICK)) u_gs_supervisor (.clk_sys, .rst_n, .avsAddress,
        .avsRead, .avsWrite, .avsWritedata, .avsReaddata, .avsWaitrequest, .doorClosedPin,
        .actPresentPin, .codeMatchPin, .codeStoredPin, .safetyInputA, .safetyInputB,
        .actBadPin(imm[0]), .comboBadPin(imm[1]), .intFaultPin(imm[2]),
        .supplyFaultPin(imm[3]), .outAFaultPin(wrn[0]), .outBFaultPin(wrn[1]),
        .crossShortPin(wrn[2]), .overTempPin(wrn[3]), .teachNvPin, .inhibitNvPin,
        .safetyOutputA, .safetyOutputB, .diagOut, .ledGreen, .ledRed, .ledYellow,
        .teachNvOut, .inhibitNvOut, .codeCapture, .codeCommit);
    gs_monitor_model u_gs_monitor_model (.clk_sys, .rst_n, .chA(safetyOutputA),
        .chB(safetyOutputB), .monEnable, .monDiscrep);
    initial forever #4 clk_sys = ~clk_sys;
    // ****************
    // Helpers
    // ****************
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int c); repeat (c) @(posedge clk_sys); endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avsAddress <= a; avsWritedata <= d; avsWrite <= wr; avsRead <= !wr;
        do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 0; avsRead <= 0;
    endtask
    task waitOut(input logic exp, input int lim);
        int k;
        k = 0;
        while (safetyOutputA !== exp && k < lim) begin @(posedge clk_sys); k++; end
        chk(safetyOutputA, exp);
    endtask
    task pwr(input logic nvT, input logic nvI);
        rst_n <= 0; teachNvPin <= nvT; inhibitNvPin <= nvI;
        cyc(5); rst_n <= 1; cyc(12);
    endtask
    task doorCycle; doorClosedPin <= 0; cyc(10); doorClosedPin <= 1; endtask
    task flashes(output int c);
        int d, k;
        logic p;
        c = 0; d = 0; k = 0;
        while (d < 8 && k < 400) begin @(posedge clk_sys); k++; d = ledRed ? 0 : d + 1; end
        d = 0;
        while ((c == 0 || d < 8) && k < 800) begin
            p = ledRed; @(posedge clk_sys); k++;
            if (ledRed && !p) c++;
            d = ledRed ? 0 : d + 1;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_run;
        bus(0, 4'h0, 0); chk(q, 0);
        bus(0, 4'hc, 0); chk(q, 0);
        bus(1, 4'h8, 32'hffffffff); bus(0, 4'h8, 0); chk(q, 0);
        doorClosedPin <= 1; actPresentPin <= 1; codeMatchPin <= 1;
        waitOut(1, 20);
        chk({ledGreen, ledYellow, ledRed, diagOut}, 4'hd);
        cyc(10); chk({monEnable, monDiscrep}, 2'h2);
        doorClosedPin <= 0; waitOut(0, 8);
        cyc(4); chk({ledYellow, diagOut}, 0);
        doorClosedPin <= 1; waitOut(1, 20);
        $display("test run done");
    endtask
    task t_imm;
        for (i = 0; i < 4; i++) begin
            imm[i] <= 1; waitOut(0, 8);
            bus(0, 4'h8, 0); chk(q[5:3], i < 2 ? i + 5 : 7);
            if (i == 0) begin flashes(n); chk(n, 5); end
            if (i > 1) begin cyc(5); chk(ledRed, 1); end
            imm[i] <= 0; cyc(20); chk(safetyOutputA, 0);
            doorCycle; waitOut(1, 20);
        end
        $display("test immediate faults done");
    endtask
    task t_warn;
        for (i = 0; i < 4; i++) begin
            wrn[i] <= 1; cyc(10);
            bus(0, 4'h8, 0); chk(q[2:0], i + 1);
            chk({safetyOutputA, diagOut, ledGreen, ledYellow}, 4'hb);
            if (i == 3) begin flashes(n); chk(n, 4); end
            wrn[i] <= 0; cyc(10); chk(diagOut, 1);
        end
        wrn[3] <= 1; cyc(18000 * TICK - 200); chk(safetyOutputA, 1);
        waitOut(0, 400);
        wrn[3] <= 0; cyc(10); chk(safetyOutputA, 0);
        doorCycle; waitOut(1, 20);
        $display("test warnings done");
    endtask
    task t_lock;
        wrn[1:0] <= 2'h3; waitOut(0, 20);
        bus(0, 4'h4, 0); chk(q[6], 1);
        wrn[1:0] <= 0; cyc(10); doorCycle; cyc(20); chk(safetyOutputA, 0);
        pwr(0, 0); waitOut(1, 30);
        $display("test lockout done");
    endtask
    task t_teach;
        codeMatchPin <= 0; codeStoredPin <= 1; actPresentPin <= 0;
        pwr(0, 0); bus(1, 4'h0, 32'h1);
        actPresentPin <= 1; waitOut(0, 10);
        cyc(12); chk(ledRed, 0);
        bus(1, 4'h0, 32'h2);
        for (i = 0; i < 20 && codeCapture !== 1'b1; i++) cyc(1);
        chk(codeCapture, 1);
        cyc(8); chk({ledGreen, ledRed}, 2'h1);
        y0 = ledYellow; cyc(5 * TICK); chk(ledYellow, !y0);
        cyc(100 * TICK); y0 = ledYellow; cyc(TICK); chk(ledYellow, !y0);
        chk(teachNvOut, 1);
        cyc(3000 * TICK); flashes(n); chk(n, 5);
        chk(teachNvOut, 0);
        actPresentPin <= 0; pwr(1, 0); bus(1, 4'h0, 32'h2);
        actPresentPin <= 1; codeMatchPin <= 1;
        for (i = 0; i < 50 && codeCommit !== 1'b1; i++) cyc(1);
        chk(codeCommit, 1);
        cyc(10); chk({safetyOutputA, inhibitNvOut}, 2'h1);
        cyc(3000 * TICK); pwr(0, 1);
        cyc(6000 * TICK - 100); chk(safetyOutputA, 0);
        y0 = ledGreen; cyc(5 * TICK); chk(ledGreen, !y0);
        waitOut(1, 300);
        $display("test teach done");
    endtask
    initial begin
        cyc(5);
        rst_n <= 1;
        cyc(12);
        t_run; t_imm; t_warn; t_lock; t_teach;
        summarize;
    end
    initial begin
        cyc(80000);
        error_cnt++;
        summarize;
    end
endmodule // gs_supervisor_test
bind gs_supervisor gs_supervisor_asserts u_gs_supervisor_asserts (.clk_sys, .rst_n,
    .doorClosedPin, .codeMatchPin, .actBadPin, .comboBadPin, .intFaultPin, .supplyFaultPin,
    .outAFaultPin, .outBFaultPin, .overTempPin, .safetyOutputA, .safetyOutputB, .diagOut,
    .ledGreen, .ledRed, .ledYellow, .inhibitNvOut, .codeCapture);

// ### verilog/gs_defs.vh
`ifndef GS_DEFS_VH
`define GS_DEFS_VH
// ****************
// Register map
// ****************
`define GS_OFS_CTRL 4'h0
`define GS_OFS_STAT 4'h4
`define GS_OFS_FLT 4'h8
`define GS_CTRL_SINGLE 0
`define GS_CTRL_RETEACH 1
`define GS_CTRL_RST 2'h0
// ****************
// Timing
// ****************
`define GS_CLK_KHZ 125000
`define GS_TICK_MS 100
`define GS_TEACH_IND_S 10
`define GS_TEACH_REQ_MIN 5
`define GS_INHIBIT_MIN 10
`define GS_WARN_MIN 30
`define GS_SLOW_TICKS 5
`define GS_PAUSE_TICKS 5'h0a
`define GS_INIT_CYC 3'h7
// ****************
// Flash codes
// ****************
`define GS_FC_NONE 3'h0
`define GS_FC_OUTA 3'h1
`define GS_FC_OUTB 3'h2
`define GS_FC_CROSS 3'h3
`define GS_FC_TEMP 3'h4
`define GS_FC_ACT 3'h5
`define GS_FC_COMBO 3'h6
`define GS_FC_STEADY 3'h7
`endif

// ### verilog/gs_supervisor.v
// Summary of operation
// RULE_01: Opening the door drops both safety outputs at once.
// RULE_02: Teach-in after power-up: green off, red on, yellow flashes 1 Hz.
// RULE_03: After 10 s of teach-in, yellow flashes briefly at 5 Hz.
// RULE_04: No power-off within 5 minutes aborts teach-in with five red pulses.
// RULE_05: After power returns, code is committed once the actuator is seen.
// RULE_06: Re-teachable variant teaches repeatedly; new code replaces old.
// RULE_07: After re-teach, outputs stay inhibited for ten minutes.
// RULE_08: Green flashes until inhibit expires and new actuator is seen.
// RULE_09: Power loss during inhibit restarts full ten minutes at power-up.
// RULE_10: Internal errors drop the safety outputs at once.
// RULE_11: Output, temperature and short faults only delay the shutdown; fOutA and fOutB together set lock_r and drop outputs at once.
// RULE_12: Error clears after cause removed and door opened and closed.
// RULE_13: Both outputs faulty or cross short locks out until power cycle.
// RULE_14: Warning keeps outputs on, forces them off 30 minutes later.
// RULE_15: During a warning the diagnostic output goes low.
// RULE_16: A warning clears by itself once its cause is gone.
// RULE_17: Closed with actuator: green, yellow, diag high; else yellow off.
// RULE_18: Warning with actuator: green and yellow steady, red flash code.
// RULE_19: Warning codes 1 to 4 red pulses, shutdown after 30 minutes.
// RULE_20: Codes 5, 6 and steady red switch off immediately.
// RULE_21: Monitor should use 100 ms discrepancy time.
// RULE_22: Monitor must ignore about 1 ms output test pulses.
// RULE_23: Flash-code groups are separated by a long dark pause.
`include "gs_defs.vh"
module gs_supervisor #(
    parameter TICK_CYC = `GS_TICK_MS * `GS_CLK_KHZ
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [3:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWritedata,
    output reg  [31:0] avsReaddata,
    output wire        avsWaitrequest,
    input  wire        doorClosedPin,
    input  wire        actPresentPin,
    input  wire        codeMatchPin,
    input  wire        codeStoredPin,
    input  wire        safetyInputA,
    input  wire        safetyInputB,
    input  wire        actBadPin,
    input  wire        comboBadPin,
    input  wire        intFaultPin,
    input  wire        supplyFaultPin,
    input  wire        outAFaultPin,
    input  wire        outBFaultPin,
    input  wire        crossShortPin,
    input  wire        overTempPin,
    input  wire        teachNvPin,
    input  wire        inhibitNvPin,
    output wire        safetyOutputA,
    output wire        safetyOutputB,
    output reg         diagOut,
    output reg         ledGreen,
    output reg         ledRed,
    output reg         ledYellow,
    output reg         teachNvOut,
    output reg         inhibitNvOut,
    output reg         codeCapture,
    output reg         codeCommit
);
    // ****************
    // Constants
    // ****************
    localparam [15:0] T_IND  = `GS_TEACH_IND_S * 1000 / `GS_TICK_MS;
    localparam [15:0] T_REQ  = `GS_TEACH_REQ_MIN * 60000 / `GS_TICK_MS;
    localparam [15:0] T_INH  = `GS_INHIBIT_MIN * 60000 / `GS_TICK_MS;
    localparam [15:0] T_WARN = `GS_WARN_MIN * 60000 / `GS_TICK_MS;
    localparam [31:0] TICK_LAST = TICK_CYC - 1;
    localparam [6:0] S_INIT  = 7'h01;
    localparam [6:0] S_RUN   = 7'h02;
    localparam [6:0] S_TIND  = 7'h04;
    localparam [6:0] S_TREQ  = 7'h08;
    localparam [6:0] S_TFAIL = 7'h10;
    localparam [6:0] S_TCONF = 7'h20;
    localparam [6:0] S_INH   = 7'h40;

    // ****************
    // Pin synchronisers
    // ****************
    wire [15:0] pinRaw = {inhibitNvPin, teachNvPin, overTempPin,
                          crossShortPin, outBFaultPin, outAFaultPin,
                          supplyFaultPin, intFaultPin, comboBadPin,
                          actBadPin, safetyInputB, safetyInputA,
                          codeStoredPin, codeMatchPin, actPresentPin,
                          doorClosedPin};
    reg  [15:0] syA_r;
    reg  [15:0] syB_r;
    reg  [15:0] syC_r;
    reg  [15:0] pinF_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syA_r  <= 16'h0000;
            syB_r  <= 16'h0000;
            syC_r  <= 16'h0000;
            pinF_r <= 16'h0000;
        end else begin
            syA_r  <= pinRaw;
            syB_r  <= syA_r;
            syC_r  <= syB_r;
            pinF_r <= (syB_r & syC_r) | (pinF_r & (syB_r ^ syC_r));
        end
    end
    wire door    = pinF_r[0];
    wire actIn   = pinF_r[1];
    wire codeOk  = pinF_r[2];
    wire stored  = pinF_r[3];
    wire chainOk = pinF_r[4] & pinF_r[5];
    wire fActBad = pinF_r[6];
    wire fCombo  = pinF_r[7];
    wire fInt    = pinF_r[8] | pinF_r[9];
    wire fOutA   = pinF_r[10];
    wire fOutB   = pinF_r[11];
    wire fCross  = pinF_r[12];
    wire fTemp   = pinF_r[13];
    wire nvTeach = pinF_r[14];
    wire nvInh   = pinF_r[15];

    // ****************
    // Tick divider
    // ****************
    reg  [31:0] divCnt_r;
    reg         tick_r;
    reg  [2:0]  slowCnt_r;
    reg         slowPh_r;
    reg         fastPh_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r  <= 32'h0;
            tick_r    <= 1'b0;
            slowCnt_r <= 3'h0;
            slowPh_r  <= 1'b0;
            fastPh_r  <= 1'b0;
        end else begin
            tick_r <= (divCnt_r == TICK_LAST);
            if (divCnt_r == TICK_LAST) begin
                divCnt_r <= 32'h0;
            end else begin
                divCnt_r <= divCnt_r + 32'h1;
            end
            if (tick_r) begin
                fastPh_r <= ~fastPh_r;
                if (slowCnt_r == `GS_SLOW_TICKS - 1) begin
                    slowCnt_r <= 3'h0;
                    slowPh_r  <= ~slowPh_r;
                end else begin
                    slowCnt_r <= slowCnt_r + 3'h1;
                end
            end
        end
    end

    // ****************
    // Register bus
    // ****************
    reg         ack_r;
    reg  [1:0]  ctrl_r;
    wire        req = avsRead | avsWrite;
    assign avsWaitrequest = req & ~ack_r;
    wire        single  = ctrl_r[`GS_CTRL_SINGLE];
    wire        reteach = ctrl_r[`GS_CTRL_RETEACH];

    // ****************
    // Fault handling
    // ****************
    reg  [15:0] warnTmr_r;
    reg         errLat_r;
    reg  [2:0]  errCode_r;
    reg         sawOpen_r;
    reg         lock_r;
    reg  [2:0]  warnCode;
    wire        warnAny = fOutA | fOutB | fCross | fTemp;
    wire        warnExp = warnAny & (warnTmr_r >= T_WARN);
    wire        immCause = fActBad | fCombo | fInt;
    always @* begin
        // Pulse count selection
        if (fCross | (fOutA & fOutB)) begin
            warnCode = `GS_FC_CROSS;
        end else if (fOutA) begin
            warnCode = `GS_FC_OUTA;
        end else if (fOutB) begin
            warnCode = `GS_FC_OUTB;
        end else if (fTemp) begin
            warnCode = `GS_FC_TEMP;
        end else begin
            warnCode = `GS_FC_NONE;
        end
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warnTmr_r <= 16'h0;
            errLat_r  <= 1'b0;
            errCode_r <= `GS_FC_NONE;
            sawOpen_r <= 1'b0;
            lock_r    <= 1'b0;
        end else begin
            // RULE_16: auto clear
            if (!warnAny) begin
                warnTmr_r <= 16'h0;
            // RULE_14: 30 min delay
            end else if (tick_r && !warnExp) begin
                warnTmr_r <= warnTmr_r + 16'h1;
            end
            // RULE_13: lockout latch
            if ((fOutA & fOutB) | (fCross & warnExp)) begin
                lock_r <= 1'b1;
            end
            if (errLat_r && !door) begin
                sawOpen_r <= 1'b1;
            end
            // RULE_10: immediate latch
            if (immCause | warnExp) begin
                errLat_r <= 1'b1;
                sawOpen_r <= 1'b0;
                // RULE_20: code select
                if (fInt) begin
                    errCode_r <= `GS_FC_STEADY;
                end else if (fCombo) begin
                    errCode_r <= `GS_FC_COMBO;
                end else if (fActBad) begin
                    errCode_r <= `GS_FC_ACT;
                end else begin
                    errCode_r <= warnCode;
                end
            // RULE_12: door cycle clear
            end else if (errLat_r && sawOpen_r && door) begin
                errLat_r  <= 1'b0;
                sawOpen_r <= 1'b0;
                errCode_r <= `GS_FC_NONE;
            end
        end
    end

    // ****************
    // Teach sequencer
    // ****************
    reg  [6:0]  state_r;
    reg  [6:0]  state_nxt;
    reg  [15:0] tmr_r;
    reg  [2:0]  initCnt_r;
    reg         teachWin_r;
    wire        mayTeach = (single & ~stored) | reteach;
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_INIT: begin
                // RULE_09: inhibit restart
                if (initCnt_r == `GS_INIT_CYC) begin
                    if (nvTeach) begin
                        state_nxt = S_TCONF;
                    end else if (nvInh) begin
                        state_nxt = S_INH;
                    end else begin
                        state_nxt = S_RUN;
                    end
                end
            end
            S_RUN: begin
                // RULE_06: repeated teach
                if (teachWin_r && mayTeach && actIn && !codeOk) begin
                    state_nxt = S_TIND;
                end
            end
            S_TIND: begin
                // RULE_03: request power off
                if (tmr_r >= T_IND) begin
                    state_nxt = S_TREQ;
                end
            end
            S_TREQ: begin
                // RULE_04: abort teach
                if (tmr_r >= T_REQ) begin
                    state_nxt = S_TFAIL;
                end
            end
            S_TFAIL: begin
                state_nxt = S_TFAIL;
            end
            S_TCONF: begin
                // RULE_05: commit on detect
                if (actIn) begin
                    state_nxt = reteach ? S_INH : S_RUN;
                end
            end
            S_INH: begin
                // RULE_08: leave inhibit
                if (tmr_r >= T_INH && codeOk) begin
                    state_nxt = S_RUN;
                end
            end
            default: begin
                state_nxt = S_INIT;
            end
        endcase
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= S_INIT;
            tmr_r        <= 16'h0;
            initCnt_r    <= 3'h0;
            teachWin_r   <= 1'b1;
            teachNvOut   <= 1'b0;
            inhibitNvOut <= 1'b0;
            codeCapture  <= 1'b0;
            codeCommit   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            codeCapture <= (state_r == S_RUN) && (state_nxt == S_TIND);
            codeCommit  <= (state_r == S_TCONF) && (state_nxt != S_TCONF);
            if (initCnt_r != `GS_INIT_CYC) begin
                initCnt_r <= initCnt_r + 3'h1;
            end
            if (state_nxt != state_r) begin
                tmr_r <= 16'h0;
            end else if (tick_r && tmr_r != 16'hffff) begin
                tmr_r <= tmr_r + 16'h1;
            end
            if (state_r == S_RUN && codeOk) begin
                teachWin_r <= 1'b0;
            end
            if (state_nxt == S_TREQ) begin
                teachNvOut <= 1'b1;
            end else if (state_nxt == S_TFAIL || state_nxt == S_INH
                         || state_nxt == S_RUN) begin
                teachNvOut <= 1'b0;
            end
            // RULE_07: hold inhibit
            inhibitNvOut <= (state_nxt == S_INH);
        end
    end

    // ****************
    // Flash code
    // ****************
    reg  [4:0]  fcCnt_r;
    reg  [2:0]  redCode;
    wire [4:0]  fcLen = {1'b0, redCode, 1'b0} + `GS_PAUSE_TICKS;
    wire        fcLit = (redCode == `GS_FC_STEADY) |
                        ((fcCnt_r < {1'b0, redCode, 1'b0}) & ~fcCnt_r[0]);
    always @* begin
        if (state_r == S_TFAIL) begin
            redCode = `GS_FC_ACT;
        end else if (errLat_r | lock_r) begin
            redCode = errCode_r;
        end else begin
            redCode = warnCode;
        end
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fcCnt_r <= 5'h0;
        // RULE_23: group pause
        end else if (tick_r) begin
            fcCnt_r <= (fcCnt_r >= fcLen - 5'h1) ? 5'h0 : fcCnt_r + 5'h1;
        end
    end

    // ****************
    // Outputs
    // ****************
    reg         on_r;
    wire        inRun = (state_r == S_RUN);
    wire        good  = door & codeOk & ~errLat_r & ~lock_r;
    assign safetyOutputA = on_r;
    assign safetyOutputB = on_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_r      <= 1'b0;
            diagOut   <= 1'b0;
            ledGreen  <= 1'b0;
            ledRed    <= 1'b0;
            ledYellow <= 1'b0;
        end else begin
            // RULE_01: door gate
            // RULE_11: warnings keep outputs
            on_r    <= inRun & good & chainOk & ~immCause;
            // RULE_15: diag low on warning
            // RULE_17: diag state
            diagOut <= inRun & good & chainOk & ~immCause & ~warnAny;
            case (state_r)
                // RULE_02: teach indication
                S_TIND: begin
                    ledGreen  <= 1'b0;
                    ledRed    <= 1'b1;
                    ledYellow <= slowPh_r;
                end
                S_TREQ: begin
                    ledGreen  <= 1'b0;
                    ledRed    <= 1'b1;
                    ledYellow <= fastPh_r;
                end
                S_TFAIL: begin
                    ledGreen  <= 1'b1;
                    ledRed    <= fcLit;
                    ledYellow <= 1'b0;
                end
                S_INH: begin
                    ledGreen  <= slowPh_r;
                    ledRed    <= 1'b0;
                    ledYellow <= 1'b0;
                end
                // RULE_18: warning display
                // RULE_19: pulse codes
                S_RUN: begin
                    ledGreen  <= 1'b1;
                    ledRed    <= fcLit;
                    ledYellow <= good;
                end
                default: begin
                    ledGreen  <= 1'b1;
                    ledRed    <= 1'b0;
                    ledYellow <= 1'b0;
                end
            endcase
        end
    end

    // ****************
    // Bus slave
    // ****************
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_r       <= 1'b0;
            ctrl_r      <= `GS_CTRL_RST;
            avsReaddata <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            if (avsWrite && ack_r && avsAddress == `GS_OFS_CTRL) begin
                ctrl_r <= avsWritedata[1:0];
            end
            case (avsAddress)
                `GS_OFS_CTRL: avsReaddata <= {30'h0, ctrl_r};
                `GS_OFS_STAT: avsReaddata <= {17'h0, state_r, 1'b0, lock_r,
                                              errLat_r, warnAny, teachNvOut,
                                              inhibitNvOut, diagOut, on_r};
                `GS_OFS_FLT:  avsReaddata <= {warnTmr_r, 10'h0,
                                              errCode_r, warnCode};
                default:      avsReaddata <= 32'h0;
            endcase
        end
    end
endmodule // gs_supervisor
